// >>> include/rma_params.svh
// constants for the remote mode arbiter
`ifndef RMA_PARAMS_SVH
`define RMA_PARAMS_SVH
`define RMA_VAR_KEYED 2'h0
`define RMA_VAR_KEYED_STEP 2'h1
`define RMA_VAR_OLDEST 2'h2
`define RMA_VAR_COMPACT 2'h3
`define RMA_DEST_MAX 3'h4
`define RMA_DEST_MIN 3'h1
`define RMA_COPY_WORDS 16'h0100
`define RMA_COPY_BUSY_TIME_NS 10
`define RMA_COPY_STEP_CYC ((`RMA_COPY_BUSY_TIME_NS + 9) / 10)
`endif

// >>> include/rma_pkg.sv
// types for the remote mode arbiter
package rma_pkg;
  typedef enum logic [2:0] {
    RMA_ST_STOP = 3'h0,
    RMA_ST_RUN = 3'h1,
    RMA_ST_PAUSE = 3'h2,
    RMA_ST_STEP = 3'h3
  } rma_state_e;
  typedef enum logic [3:0] {
    RMA_CMD_NONE = 4'h0,
    RMA_CMD_RUN = 4'h1,
    RMA_CMD_STOP = 4'h2,
    RMA_CMD_PAUSE = 4'h3,
    RMA_CMD_STEP = 4'h4,
    RMA_CMD_LATCH_CLR = 4'h5,
    RMA_CMD_RESET = 4'h6,
    RMA_CMD_SWITCH = 4'h7,
    RMA_CMD_MODE_CHG = 4'h8,
    RMA_CMD_MEM_COPY = 4'h9
  } rma_cmd_e;
  typedef enum logic [1:0] {
    RMA_DST_SELF = 2'h0,
    RMA_DST_ALL = 2'h1,
    RMA_DST_GROUP = 2'h2,
    RMA_DST_PAIR = 2'h3
  } rma_dest_e;
  typedef struct packed {
    rma_cmd_e cmd;
    rma_dest_e dest;
    logic [2:0] module_count;
    logic [7:0] group_num;
    logic other_host;
  } rma_req_s;
  typedef struct packed {
    logic accepted;
    logic refused;
  } rma_ack_s;
endpackage

// >>> hw/rma_copy_engine.sv
// memory copy sequencer for the redundant pair
`timescale 1ns/100ps
`default_nettype none
`include "rma_params.svh"
module rma_copy_engine
  import rma_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic link_fault,
  // status
  output logic busy,
  output logic [15:0] progress,
  output logic failed
);
  logic busy_reg, busy_next;
  logic failed_reg, failed_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [7:0] tick_reg, tick_next;

  always_comb
  begin
    busy_next = busy_reg;
    failed_next = failed_reg;
    cnt_next = cnt_reg;
    tick_next = tick_reg;
    if (!busy_reg && start)
    begin
      busy_next = 1'b1;
      failed_next = 1'b0;
      cnt_next = 16'h0000;
      tick_next = 8'h00;
    end
    else if (busy_reg)
    begin
      if (link_fault)
      begin
        busy_next = 1'b0;
        failed_next = 1'b1;
      end
      else if (tick_reg == 8'((`RMA_COPY_STEP_CYC) - 1))
      begin
        tick_next = 8'h00;
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_next == `RMA_COPY_WORDS)
          busy_next = 1'b0;
      end
      else
        tick_next = tick_reg + 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_reg <= 1'b0;
      failed_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      tick_reg <= 8'h00;
    end
    else
    begin
      busy_reg <= busy_next;
      failed_reg <= failed_next;
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign busy = busy_reg;
  assign progress = cnt_reg;
  assign failed = failed_reg;
endmodule
`default_nettype wire

// >>> hw/rma_arbiter.sv
// operating mode arbiter with remote requests and redundant pair control
`timescale 1ns/100ps
`default_nettype none
`include "rma_params.svh"
module rma_arbiter
  import rma_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire logic [1:0] variant,
  input wire logic remote_reset_enable,
  // local controls
  input wire rma_state_e key_switch,
  input wire logic contact_pause,
  input wire logic local_run_switch,
  // remote request port
  input wire logic req_valid,
  input wire rma_req_s req,
  output logic req_ready,
  output rma_ack_s ack,
  // redundant pair status
  input wire logic pair_present,
  input wire logic debug_mode,
  input wire logic standby_stopped,
  input wire logic copy_link_fault,
  // memory card
  input wire logic card_present,
  input wire logic card_inhibit_clear,
  input wire logic card_inhibit_set,
  // maintenance requests from elsewhere
  input wire logic format_req,
  input wire logic flash_write_req,
  output logic maint_refused,
  // state and actions
  output rma_state_e eff_state,
  output logic reset_pulse,
  output logic latch_clear_pulse,
  output logic standby_reset_pulse,
  output logic is_control,
  output logic separate_mode,
  output logic forced_run_mode_flag,
  output logic forced_run_flag,
  output logic forced_stop_flag,
  output logic card_removal_inhibit_flag,
  output logic card_error,
  // memory copy status
  output logic copy_busy,
  output logic [15:0] copy_progress,
  output logic copy_failed
);
  // ----------------------------------------
  // request decode helpers
  // ----------------------------------------
  function automatic logic cmd_supported(input logic [1:0] v, input rma_cmd_e c);
    logic ok;
    ok = 1'b1;
    if (v == `RMA_VAR_COMPACT)
      ok = (c == RMA_CMD_RUN) || (c == RMA_CMD_STOP);
    else if (c == RMA_CMD_STEP && v != `RMA_VAR_KEYED_STEP)
      ok = 1'b0;
    else if (c == RMA_CMD_LATCH_CLR && v == `RMA_VAR_OLDEST)
      ok = 1'b0;
    return ok;
  endfunction

  function automatic logic dest_ok(input rma_req_s r);
    logic ok;
    ok = 1'b1;
    if (r.dest == RMA_DST_ALL || r.dest == RMA_DST_GROUP)
      ok = (r.module_count >= `RMA_DEST_MIN) && (r.module_count <= `RMA_DEST_MAX);
    return ok;
  endfunction

  function automatic logic is_state_cmd(input rma_cmd_e c);
    return (c == RMA_CMD_RUN) || (c == RMA_CMD_STOP) || (c == RMA_CMD_PAUSE) ||
           (c == RMA_CMD_STEP);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  rma_state_e remote_reg, remote_next;
  rma_state_e eff_reg, eff_next;
  logic ctrl_reg, ctrl_next;
  logic sep_reg, sep_next;
  logic frm_reg, frm_next;
  logic fr_reg, fr_next;
  logic fs_reg, fs_next;
  logic inh_reg, inh_next;
  logic cerr_reg, cerr_next;
  logic card_seen_reg, card_seen_next;
  logic other_reg, other_next;
  rma_ack_s ack_reg, ack_next;
  logic rst_p_reg, rst_p_next;
  logic lc_p_reg, lc_p_next;
  logic sb_p_reg, sb_p_next;
  logic mref_reg, mref_next;
  logic copy_start;
  logic cp_busy;

  // ----------------------------------------
  // request acceptance and effective state
  // ----------------------------------------
  logic compact;
  logic window_ok;
  logic redundant_cmd;
  logic take;
  logic remote_stopped;

  always_comb
  begin
    compact = (variant == `RMA_VAR_COMPACT);
    // compact accepts from run or stop; keyed window is open only at key run
    if (compact)
      window_ok = (eff_reg == RMA_ST_RUN) || (eff_reg == RMA_ST_STOP);
    else
      window_ok = (key_switch == RMA_ST_RUN);
    redundant_cmd = (req.cmd == RMA_CMD_SWITCH) || (req.cmd == RMA_CMD_MODE_CHG) ||
                    (req.cmd == RMA_CMD_MEM_COPY);
    remote_stopped = (remote_reg == RMA_ST_STOP);
    take = req_valid && dest_ok(req);

    remote_next = remote_reg;
    ctrl_next = ctrl_reg;
    sep_next = sep_reg;
    frm_next = frm_reg;
    fr_next = fr_reg;
    fs_next = fs_reg;
    other_next = other_reg;
    ack_next = '0;
    rst_p_next = 1'b0;
    lc_p_next = 1'b0;
    sb_p_next = 1'b0;
    copy_start = 1'b0;

    if (take)
    begin
      ack_next.refused = 1'b1;
      if (redundant_cmd)
      begin
        if (pair_present && !debug_mode && !cp_busy)
        begin
          ack_next = '{accepted: 1'b1, refused: 1'b0};
          unique case (req.cmd)
            RMA_CMD_SWITCH: ctrl_next = !ctrl_reg;
            RMA_CMD_MODE_CHG: sep_next = !sep_reg;
            default: copy_start = ctrl_reg;
          endcase
          if (req.cmd == RMA_CMD_MEM_COPY && !ctrl_reg)
            ack_next = '{accepted: 1'b0, refused: 1'b1};
        end
      end
      else if (!cmd_supported(variant, req.cmd))
        ack_next.refused = 1'b1;
      else if (compact)
      begin
        if (window_ok)
        begin
          ack_next = '{accepted: 1'b1, refused: 1'b0};
          frm_next = 1'b1;
          fr_next = (req.cmd == RMA_CMD_RUN);
          fs_next = (req.cmd == RMA_CMD_STOP);
        end
      end
      else if (is_state_cmd(req.cmd))
      begin
        // state stored even under key stop, applied later
        if (window_ok || key_switch == RMA_ST_STOP)
        begin
          ack_next = '{accepted: 1'b1, refused: 1'b0};
          unique case (req.cmd)
            RMA_CMD_RUN: remote_next = RMA_ST_RUN;
            RMA_CMD_STOP: remote_next = RMA_ST_STOP;
            RMA_CMD_PAUSE: remote_next = RMA_ST_PAUSE;
            default: remote_next = RMA_ST_STEP;
          endcase
        end
      end
      else if (key_switch == RMA_ST_STOP || remote_stopped)
      begin
        if (req.cmd == RMA_CMD_LATCH_CLR)
        begin
          ack_next = '{accepted: 1'b1, refused: 1'b0};
          lc_p_next = 1'b1;
        end
        else if (remote_reset_enable)
        begin
          if (req.dest == RMA_DST_PAIR)
          begin
            if (!other_reg && !req.other_host)
            begin
              ack_next = '{accepted: 1'b1, refused: 1'b0};
              rst_p_next = 1'b1;
              sb_p_next = standby_stopped;
            end
          end
          else
          begin
            ack_next = '{accepted: 1'b1, refused: 1'b0};
            rst_p_next = 1'b1;
          end
        end
      end
      if (req.dest == RMA_DST_PAIR && req.other_host)
        other_next = 1'b1;
    end

    // priority merge: stop > pause > step > run
    if (compact)
      eff_next = fs_reg ? RMA_ST_STOP :
                 (fr_reg ? RMA_ST_RUN :
                 (frm_reg ? eff_reg : (local_run_switch ? RMA_ST_RUN : RMA_ST_STOP)));
    else if (key_switch == RMA_ST_STOP || remote_reg == RMA_ST_STOP)
      eff_next = RMA_ST_STOP;
    else if (key_switch == RMA_ST_PAUSE || remote_reg == RMA_ST_PAUSE || contact_pause)
      eff_next = RMA_ST_PAUSE;
    else if (key_switch == RMA_ST_STEP || remote_reg == RMA_ST_STEP)
      eff_next = RMA_ST_STEP;
    else
      eff_next = RMA_ST_RUN;
  end

  // ----------------------------------------
  // memory card and maintenance lockout
  // ----------------------------------------
  always_comb
  begin
    inh_next = inh_reg;
    if (card_inhibit_clear)
      inh_next = 1'b0;
    if (card_inhibit_set)
      inh_next = 1'b1;
    card_seen_next = card_present;
    cerr_next = cerr_reg || (card_seen_reg && !card_present && inh_reg);
    mref_next = cp_busy && (format_req || flash_write_req);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      remote_reg <= RMA_ST_RUN;
      eff_reg <= RMA_ST_STOP;
      ctrl_reg <= 1'b1;
      sep_reg <= 1'b0;
      frm_reg <= 1'b0;
      fr_reg <= 1'b0;
      fs_reg <= 1'b0;
      inh_reg <= 1'b1;
      cerr_reg <= 1'b0;
      card_seen_reg <= 1'b0;
      other_reg <= 1'b0;
      ack_reg <= '0;
      rst_p_reg <= 1'b0;
      lc_p_reg <= 1'b0;
      sb_p_reg <= 1'b0;
      mref_reg <= 1'b0;
    end
    else
    begin
      remote_reg <= remote_next;
      eff_reg <= eff_next;
      ctrl_reg <= ctrl_next;
      sep_reg <= sep_next;
      frm_reg <= frm_next;
      fr_reg <= fr_next;
      fs_reg <= fs_next;
      inh_reg <= inh_next;
      cerr_reg <= cerr_next;
      card_seen_reg <= card_seen_next;
      other_reg <= other_next;
      ack_reg <= ack_next;
      rst_p_reg <= rst_p_next;
      lc_p_reg <= lc_p_next;
      sb_p_reg <= sb_p_next;
      mref_reg <= mref_next;
    end
  end

  // ----------------------------------------
  // copy engine
  // ----------------------------------------
  rma_copy_engine u_copy (
    .clk(clk),
    .rst(rst),
    .start(copy_start),
    .link_fault(copy_link_fault),
    .busy(cp_busy),
    .progress(copy_progress),
    .failed(copy_failed)
  );

  // one request per cycle, ready always high; requests failing dest_ok are dropped
  assign req_ready = 1'b1;
  assign ack = ack_reg;
  assign eff_state = eff_reg;
  assign reset_pulse = rst_p_reg;
  assign latch_clear_pulse = lc_p_reg;
  assign standby_reset_pulse = sb_p_reg;
  assign is_control = ctrl_reg;
  assign separate_mode = sep_reg;
  assign forced_run_mode_flag = frm_reg;
  assign forced_run_flag = fr_reg;
  assign forced_stop_flag = fs_reg;
  assign card_removal_inhibit_flag = inh_reg;
  assign card_error = cerr_reg;
  assign copy_busy = cp_busy;
  assign maint_refused = mref_reg;
endmodule
`default_nettype wire

// >>> verif/rma_arbiter_sva.sv
// checker for the remote mode arbiter
`timescale 1ns/100ps
`default_nettype none
module rma_arbiter_sva
  import rma_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched inputs
  input wire logic [1:0] variant,
  input wire logic remote_reset_enable,
  input wire rma_state_e key_switch,
  input wire logic req_valid,
  input wire rma_req_s req,
  input wire logic debug_mode,
  input wire logic standby_stopped,
  input wire logic format_req,
  // watched outputs
  input wire rma_ack_s ack,
  input wire rma_state_e eff_state,
  input wire logic standby_reset_pulse,
  input wire logic is_control,
  input wire logic maint_refused,
  input wire logic copy_busy
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic lg;
  assign lg = req_valid && (req.dest inside {RMA_DST_SELF, RMA_DST_PAIR}
    || req.module_count inside {[3'h1:3'h4]});
  ack_follows_a: assert property (lg |=> ack.accepted ^ ack.refused)
    else $error("request not answered");
  compact_subset_a: assert property (lg && variant == 2'h3 && req.cmd inside
    {RMA_CMD_PAUSE, RMA_CMD_STEP, RMA_CMD_LATCH_CLR, RMA_CMD_RESET} |=> ack.refused)
    else $error("compact took unsupported command");
  reset_enable_a: assert property (lg && req.cmd == RMA_CMD_RESET
    && !remote_reset_enable |=> ack.refused)
    else $error("reset taken while disabled");
  debug_block_a: assert property (lg && debug_mode && req.cmd inside
    {RMA_CMD_SWITCH, RMA_CMD_MODE_CHG, RMA_CMD_MEM_COPY} |=> ack.refused)
    else $error("pair command taken in debug");
  switch_swap_a: assert property (ack.accepted && $past(req.cmd) == RMA_CMD_SWITCH
    |-> is_control != $past(is_control))
    else $error("roles not swapped");
  standby_gate_a: assert property (standby_reset_pulse |-> $past(standby_stopped))
    else $error("standby reset while running");
  key_stop_a: assert property ((key_switch == RMA_ST_STOP && variant != 2'h3)[*3]
    |-> eff_state == RMA_ST_STOP)
    else $error("left stop with key at stop");
  copy_maint_a: assert property (copy_busy && format_req |=> maint_refused)
    else $error("format not refused during copy");
  cover property ($fell(copy_busy));
  cover property (standby_reset_pulse);
  cover property (ack.refused);
endmodule
bind rma_arbiter rma_arbiter_sva rma_arbiter_sva_inst (.*);
`default_nettype wire

// >>> verif/rma_host_model.sv
// host tool model that issues remote requests
`timescale 1ns/100ps
`default_nettype none
module rma_host_model
  import rma_pkg::*;
(
  // clock
  input wire logic clk,
  // request side
  output logic req_valid,
  output rma_req_s req
);
  // ---------
  // requester
  // ---------
  initial req_valid = 1'b0;
  initial req = '0;
  // called just after an edge; reset goes as a datagram, no reconnect
  task automatic send(input rma_req_s r, input int gap);
    req_valid = 1'b1;
    req = r;
    @(posedge clk);
    #1;
    if (gap > 0)
    begin
      req_valid = 1'b0;
      // scrambled while idle so stale fields never match the last request
      req = rma_req_s'(~r);
      repeat (gap) @(posedge clk);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the remote mode arbiter
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import rma_pkg::*;
;
  // -----
  // bench
  // -----
  logic clk, rst, remote_reset_enable, contact_pause, local_run_switch, req_valid, req_ready;
  logic pair_present, debug_mode, standby_stopped, copy_link_fault, card_present;
  logic card_inhibit_clear, card_inhibit_set, format_req, flash_write_req, maint_refused;
  logic reset_pulse, latch_clear_pulse, standby_reset_pulse, is_control, separate_mode;
  logic forced_run_mode_flag, forced_run_flag, forced_stop_flag, card_removal_inhibit_flag;
  logic card_error, copy_busy, copy_failed;
  logic [1:0] variant;
  logic [15:0] copy_progress;
  logic [31:0] lf;
  rma_state_e key_switch, eff_state;
  rma_req_s req;
  rma_ack_s ack;
  logic [1:0] ackq[$];
  int error_cnt, n_checks, i;
  int pc[3];
  localparam logic [1:0] acc_v = 2'h2;
  localparam logic [1:0] ref_v = 2'h1;
  rma_cmd_e bad[4] = '{RMA_CMD_PAUSE, RMA_CMD_STEP, RMA_CMD_LATCH_CLR, RMA_CMD_RESET};
  rma_arbiter rma_arbiter_inst (.*);
  rma_host_model rma_host_model_inst (.*);
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rq(input rma_cmd_e c, input rma_dest_e d, input logic [2:0] n,
    input logic o, input logic [1:0] e);
    rma_req_s r;
    lf = lfsr_step(lf);
    r = '{cmd: c, dest: d, module_count: n, group_num: lf[7:0], other_host: o};
    if (e != 2'h0)
      ackq.push_back(e);
    rma_host_model_inst.send(r, 3);
  endtask
  task automatic rs(input rma_cmd_e c, input logic [1:0] e);
    rq(c, RMA_DST_SELF, 3'h0, 1'b0, e);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #50000;
    error_cnt++;
    conclude();
  end
  always @(posedge clk)
  begin
    #2;
    pc[0] += int'(reset_pulse === 1'b1);
    pc[1] += int'(latch_clear_pulse === 1'b1);
    pc[2] += int'(standby_reset_pulse === 1'b1);
    if (!rst && ack !== 2'h0)
      ck(ack, ackq.size() > 0 ? ackq.pop_front() : 2'h0);
  end
  initial
  begin
    {rst, remote_reset_enable, card_present} = 3'h7;
    {contact_pause, local_run_switch, pair_present, debug_mode, standby_stopped} = 5'h0;
    {copy_link_fault, card_inhibit_clear, card_inhibit_set, format_req, flash_write_req} = 5'h0;
    variant = 2'h0;
    key_switch = RMA_ST_RUN;
    lf = 32'h055D;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    ck({eff_state, is_control, separate_mode, card_removal_inhibit_flag}, 6'h05);
    ck(req_ready, 1'b1);
    rs(RMA_CMD_RUN, acc_v);
    ck(eff_state, RMA_ST_RUN);
    rs(RMA_CMD_RESET, ref_v);
    rs(RMA_CMD_STEP, ref_v);
    rs(RMA_CMD_STOP, acc_v);
    ck(eff_state, RMA_ST_STOP);
    rs(RMA_CMD_RESET, acc_v);
    rs(RMA_CMD_LATCH_CLR, acc_v);
    remote_reset_enable = 1'b0;
    rs(RMA_CMD_RESET, ref_v);
    remote_reset_enable = 1'b1;
    ck({pc[0][7:0], pc[1][7:0]}, 16'h0101);
    variant = 2'h1;
    key_switch = RMA_ST_STOP;
    rs(RMA_CMD_RESET, acc_v);
    rs(RMA_CMD_STEP, acc_v);
    ck({eff_state, pc[0][7:0]}, 11'h002);
    key_switch = RMA_ST_RUN;
    step(3);
    ck(eff_state, RMA_ST_STEP);
    contact_pause = 1'b1;
    step(3);
    ck(eff_state, RMA_ST_PAUSE);
    contact_pause = 1'b0;
    key_switch = RMA_ST_PAUSE;
    rs(RMA_CMD_RUN, ref_v);
    key_switch = RMA_ST_RUN;
    variant = 2'h2;
    rs(RMA_CMD_STOP, acc_v);
    rs(RMA_CMD_LATCH_CLR, ref_v);
    rq(RMA_CMD_RUN, RMA_DST_ALL, 3'h0, 1'b0, 2'h0);
    rq(RMA_CMD_RUN, RMA_DST_GROUP, 3'h5, 1'b0, 2'h0);
    rq(RMA_CMD_RUN, RMA_DST_GROUP, 3'h4, 1'b0, acc_v);
    rq(RMA_CMD_STOP, RMA_DST_ALL, 3'h1, 1'b0, acc_v);
    variant = 2'h3;
    foreach (bad[j])
      rs(bad[j], ref_v);
    rs(RMA_CMD_RUN, acc_v);
    ck({forced_run_mode_flag, forced_run_flag, eff_state}, 5'h19);
    rs(RMA_CMD_STOP, acc_v);
    ck({forced_stop_flag, eff_state}, 4'h8);
    local_run_switch = 1'b1;
    step(2);
    ck(eff_state, RMA_ST_STOP);
    local_run_switch = 1'b0;
    rs(RMA_CMD_RUN, acc_v);
    variant = 2'h0;
    {pair_present, debug_mode} = 2'h3;
    rs(RMA_CMD_SWITCH, ref_v);
    debug_mode = 1'b0;
    rs(RMA_CMD_SWITCH, acc_v);
    ck(is_control, 1'b0);
    rs(RMA_CMD_MEM_COPY, ref_v);
    rs(RMA_CMD_SWITCH, acc_v);
    rs(RMA_CMD_MODE_CHG, acc_v);
    ck({is_control, separate_mode}, 2'h3);
    rs(RMA_CMD_MEM_COPY, acc_v);
    format_req = 1'b1;
    step(1);
    format_req = 1'b0;
    ck({copy_busy, maint_refused}, 2'h3);
    flash_write_req = 1'b1;
    step(1);
    flash_write_req = 1'b0;
    ck({copy_busy, maint_refused}, 2'h3);
    for (i = 0; i < 400 && copy_busy === 1'b1; i++)
      step(1);
    ck({copy_busy, copy_failed, copy_progress}, 18'h00100);
    format_req = 1'b1;
    step(1);
    format_req = 1'b0;
    ck(maint_refused, 1'b0);
    rs(RMA_CMD_MEM_COPY, acc_v);
    copy_link_fault = 1'b1;
    step(2);
    ck({copy_busy, copy_failed}, 2'h1);
    {copy_link_fault, standby_stopped} = 2'h1;
    rs(RMA_CMD_STOP, acc_v);
    rq(RMA_CMD_RESET, RMA_DST_PAIR, 3'h0, 1'b0, acc_v);
    ck(pc[2], 1);
    rq(RMA_CMD_RESET, RMA_DST_PAIR, 3'h0, 1'b1, ref_v);
    rq(RMA_CMD_RESET, RMA_DST_PAIR, 3'h0, 1'b0, ref_v);
    card_inhibit_clear = 1'b1;
    step(1);
    {card_inhibit_clear, card_present} = 2'h0;
    step(3);
    ck({card_removal_inhibit_flag, card_error}, 2'h0);
    {card_inhibit_set, card_present} = 2'h3;
    step(1);
    {card_inhibit_set, card_present} = 2'h0;
    step(3);
    ck({card_removal_inhibit_flag, card_error}, 2'h3);
    ck(ackq.size(), 0);
    conclude();
  end
endmodule
`default_nettype wire
